/* File: hw/ebsc_pkg.sv */
/*
  constants for the event buffer status and control block: register
  offsets, field positions, reset values and instruction codes.
  assumes a 5-bit instruction address and 20-bit register data.
*/
package ebsc_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 20;
  localparam int NCHAN  = 16;
  localparam int BUFFER_COUNT_SELECT_MAX = 8;

  // register offsets
  localparam logic [4:0] OFS_DATAPATH_CFG  = 5'h0c;
  localparam logic [4:0] OFS_PED_ADDR      = 5'h0d;
  localparam logic [4:0] OFS_BASELINE_THR  = 5'h0e;
  localparam logic [4:0] OFS_ERR_STATE     = 5'h10;
  localparam logic [4:0] OFS_TRIG_COUNT    = 5'h12;
  localparam logic [4:0] OFS_CHAN_MAP      = 5'h17;
  // command codes
  localparam logic [4:0] CMD_WPTR_ADVANCE  = 5'h18;
  localparam logic [4:0] CMD_RPTR_ADVANCE  = 5'h19;
  localparam logic [4:0] CMD_CHAN_READOUT  = 5'h1a;
  localparam logic [4:0] CMD_SOFT_TRIGGER  = 5'h1b;
  localparam logic [4:0] CMD_CLEAR_COUNT   = 5'h1c;
  localparam logic [4:0] CMD_CLEAR_ERRORS  = 5'h1d;

  // status register fields
  localparam int ST_RD_PTR_LSB   = 0;
  localparam int ST_WR_PTR_LSB   = 3;
  localparam int ST_FREE_LSB     = 6;
  localparam int ST_FULL_BIT     = 10;
  localparam int ST_EMPTY_BIT    = 11;
  localparam int ST_ERR_LSB      = 12;
  localparam int ERR_PARITY      = 0;
  localparam int ERR_INSTR       = 1;
  localparam int ERR_TRIG_OVL    = 2;
  localparam int ERR_BUF_SEU1    = 3;
  localparam int ERR_BUF_SEU2    = 4;
  localparam int ERR_IF_SEU1     = 5;
  localparam int ERR_IF_SEU2     = 6;
  localparam int ERR_NO_DATA     = 7;

  // datapath configuration field
  localparam int CFG_BUF_SEL_BIT = 4;

  // reset values
  localparam logic [9:0]  RST_PED_ADDR     = 10'h000;
  localparam logic [13:0] RST_BASELINE_THR = 14'h0000;
  localparam logic [15:0] RST_TRIG_COUNT   = 16'h0000;
  localparam logic        RST_BUF_SEL      = 1'b0;

  typedef enum logic [1:0] {
    RO_IDLE,
    RO_XFER,
    RO_HOLD
  } ebsc_ro_e;
endpackage

/* File: hw/ebsc_event_buffer_ctrl.sv */
/*
  event buffer status and control: error and status register,
  first-level trigger counter, pedestal address, baseline thresholds,
  channel occupancy map and the buffer commands.
  assumes the instruction port, datapath signals and upset reports
  share i_core_clk; only the trigger pin is asynchronous.
*/
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
module ebsc_event_buffer_ctrl (
  input  wire logic                        i_core_clk,
  input  wire logic                        i_arst_n,
  input  wire logic                        i_ce,
  input  wire logic [ebsc_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [ebsc_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  input  wire logic                        i_bcast,
  input  wire logic                        i_parity,
  input  wire logic                        i_trig_pin,
  input  wire logic                        i_proc_window,
  input  wire logic [ebsc_pkg::NCHAN-1:0]  i_chan_nonzero,
  input  wire logic                        i_readout_done,
  input  wire logic                        i_buf_fsm_single_upset,
  input  wire logic                        i_buf_fsm_double_upset,
  input  wire logic                        i_if_single_upset,
  input  wire logic                        i_if_double_upset,
  output logic      [ebsc_pkg::DATA_W-1:0] o_rdata,
  output logic                             o_trig_accept,
  output logic                             o_transfer_active,
  output logic      [3:0]                  o_readout_chan,
  output logic      [2:0]                  o_write_ptr,
  output logic      [9:0]                  o_ped_addr,
  output logic      [13:0]                 o_baseline_thr,
  output logic                             o_buf_count_select
);
  import ebsc_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0]            rdata;
    logic                         trig_sync1;
    logic                         trig_sync2;
    logic                         trig_prev;
    logic                         trig_accept;
    logic [9:0]                   ped_addr;
    logic [13:0]                  baseline_thr;
    logic                         buf_sel;
    logic [15:0]                  trig_count;
    logic [7:0]                   errors;
    logic [2:0]                   wr_ptr;
    logic [2:0]                   rd_ptr;
    logic [3:0]                   used;
    logic [BUFFER_COUNT_SELECT_MAX-1:0][NCHAN-1:0] occupancy;
    ebsc_ro_e                     ro_state;
    logic [3:0]                   ro_chan;
    logic                         xfer_active;
  } ebsc_state_s;

  ebsc_state_s st_reg;
  ebsc_state_s st_next;

  // buffer count for the selected mode
  function automatic logic [3:0] ebsc_depth(input logic sel);
    ebsc_depth = sel ? 4'h8 : 4'h4;
  endfunction

  // pointer step: even slots only in four-buffer mode
  function automatic logic [2:0] ebsc_step(input logic sel);
    ebsc_step = sel ? 3'h1 : 3'h2;
  endfunction

  // whether an address may be broadcast
  function automatic logic ebsc_bcast_ok(input logic [4:0] a);
    ebsc_bcast_ok = (a == OFS_DATAPATH_CFG) || (a == OFS_PED_ADDR) ||
                    (a == CMD_WPTR_ADVANCE) || (a == CMD_RPTR_ADVANCE) ||
                    (a == CMD_SOFT_TRIGGER) || (a == CMD_CLEAR_COUNT) ||
                    (a == CMD_CLEAR_ERRORS);
  endfunction

  logic        full;
  logic        empty;
  logic [3:0]  free_cnt;
  logic [19:0] status_word;

  always_comb
  begin
    full     = (st_reg.used == ebsc_depth(st_reg.buf_sel));
    empty    = (st_reg.used == 4'h0);
    free_cnt = ebsc_depth(st_reg.buf_sel) - st_reg.used;
    status_word = '0;
    status_word[ST_RD_PTR_LSB +: 3] = st_reg.rd_ptr;
    status_word[ST_WR_PTR_LSB +: 3] = st_reg.wr_ptr;
    status_word[ST_FREE_LSB +: 4]   = free_cnt;
    status_word[ST_FULL_BIT]        = full;
    status_word[ST_EMPTY_BIT]       = empty;
    status_word[ST_ERR_LSB +: 8]    = st_reg.errors;
  end

  logic       acc;
  logic       parity_bad;
  logic       illegal;
  logic       do_wr;
  logic       trig_edge;
  logic       soft_trig;
  logic       any_trig;
  logic       wp_adv;
  logic       rp_adv;
  logic       ro_cmd;
  logic [7:0] err_set;
  logic [2:0] step;

  always_comb
  begin
    st_next    = st_reg;
    step       = ebsc_step(st_reg.buf_sel);
    acc        = i_wr || i_rd;
    parity_bad = acc && ((^{i_addr, i_wdata, i_bcast}) != i_parity);
    illegal    = 1'b0;
    do_wr      = 1'b0;
    wp_adv     = 1'b0;
    rp_adv     = 1'b0;
    ro_cmd     = 1'b0;
    soft_trig  = 1'b0;
    err_set    = 8'h00;
    st_next.trig_accept = 1'b0;
    st_next.rdata       = '0;

    // trigger pin synchroniser and edge detect
    st_next.trig_sync1 = i_trig_pin;
    st_next.trig_sync2 = st_reg.trig_sync1;
    st_next.trig_prev  = st_reg.trig_sync2;
    trig_edge = st_reg.trig_sync2 && !st_reg.trig_prev;

    // instruction decode
    if (acc && !parity_bad)
    begin
      if (i_bcast && (i_rd || !ebsc_bcast_ok(i_addr)))
        illegal = 1'b1;
      else if (i_rd)
      begin
        unique case (i_addr)
          OFS_DATAPATH_CFG:
            st_next.rdata[CFG_BUF_SEL_BIT] = st_reg.buf_sel;
          OFS_PED_ADDR:     st_next.rdata[9:0]  = st_reg.ped_addr;
          OFS_BASELINE_THR: st_next.rdata[13:0] = st_reg.baseline_thr;
          OFS_ERR_STATE:    st_next.rdata = status_word;
          OFS_TRIG_COUNT:   st_next.rdata[15:0] = st_reg.trig_count;
          OFS_CHAN_MAP:
            st_next.rdata[15:0] = st_reg.occupancy[st_reg.rd_ptr];
          default:          illegal = 1'b1;
        endcase
      end
      else
      begin
        do_wr = 1'b1;
        unique case (i_addr)
          OFS_DATAPATH_CFG:
            st_next.buf_sel = i_wdata[CFG_BUF_SEL_BIT];
          OFS_PED_ADDR:     st_next.ped_addr = i_wdata[9:0];
          OFS_BASELINE_THR: st_next.baseline_thr = i_wdata[13:0];
          CMD_WPTR_ADVANCE: wp_adv = 1'b1;
          CMD_RPTR_ADVANCE: rp_adv = 1'b1;
          CMD_CHAN_READOUT: ro_cmd = 1'b1;
          CMD_SOFT_TRIGGER: soft_trig = 1'b1;
          CMD_CLEAR_COUNT:  st_next.trig_count = RST_TRIG_COUNT;
          CMD_CLEAR_ERRORS: st_next.errors = 8'h00;
          default:          illegal = 1'b1;
        endcase
      end
    end
    // writes other than a readout command during a readout still execute but raise the instruction error
    if (st_reg.ro_state != RO_IDLE && acc && do_wr && !ro_cmd)
      illegal = 1'b1;

    // first-level trigger handling
    any_trig = trig_edge || soft_trig;
    if (any_trig)
    begin
      st_next.trig_count = st_next.trig_count + 16'h0001;
      if (i_proc_window)
        err_set[ERR_TRIG_OVL] = 1'b1;
      if (!full)
        st_next.trig_accept = 1'b1;
    end

    // buffer pointers
    if (wp_adv && !full)
    begin
      st_next.occupancy[st_reg.wr_ptr] = i_chan_nonzero;
      st_next.wr_ptr = st_reg.wr_ptr + step;
    end
    if (rp_adv && !empty)
      st_next.rd_ptr = st_reg.rd_ptr + step;
    st_next.used = st_reg.used + {3'h0, wp_adv && !full}
                 - {3'h0, rp_adv && !empty};

    // channel readout machine
    unique case (st_reg.ro_state)
      RO_IDLE:
        if (ro_cmd)
        begin
          if (empty)
            err_set[ERR_NO_DATA] = 1'b1;
          else
          begin
            st_next.ro_state = RO_XFER;
            st_next.ro_chan  = i_wdata[3:0];
          end
        end
      RO_XFER:
        if (i_readout_done)
          st_next.ro_state = RO_IDLE;
        else if (any_trig && !full)
          st_next.ro_state = RO_HOLD;
      RO_HOLD:
        if (!i_proc_window && !st_reg.trig_accept)
          st_next.ro_state = RO_XFER;
      // unused code of the two-bit state falls back to idle
      default:
        st_next.ro_state = RO_IDLE;
    endcase
    if (i_if_double_upset)
      st_next.ro_state = RO_IDLE;
    st_next.xfer_active = (st_next.ro_state == RO_XFER);

    // buffer machine double upset drops to a clean empty state
    if (i_buf_fsm_double_upset)
    begin
      st_next.wr_ptr = 3'h0;
      st_next.rd_ptr = 3'h0;
      st_next.used   = 4'h0;
    end

    // mode change restarts pointers on a legal grid
    if (do_wr && i_addr == OFS_DATAPATH_CFG &&
        i_wdata[CFG_BUF_SEL_BIT] != st_reg.buf_sel)
    begin
      st_next.wr_ptr = 3'h0;
      st_next.rd_ptr = 3'h0;
      st_next.used   = 4'h0;
    end

    err_set[ERR_PARITY]   = parity_bad;
    err_set[ERR_INSTR]    = illegal;
    err_set[ERR_BUF_SEU1] = i_buf_fsm_single_upset;
    err_set[ERR_BUF_SEU2] = i_buf_fsm_double_upset;
    err_set[ERR_IF_SEU1]  = i_if_single_upset;
    err_set[ERR_IF_SEU2]  = i_if_double_upset;
    // set wins over clear in the same cycle
    st_next.errors = st_next.errors | err_set;
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_reg              <= '0;
      st_reg.ped_addr     <= RST_PED_ADDR;
      st_reg.baseline_thr <= RST_BASELINE_THR;
      st_reg.buf_sel      <= RST_BUF_SEL;
      st_reg.trig_count   <= RST_TRIG_COUNT;
      st_reg.errors       <= 8'h00;
      st_reg.ro_state     <= RO_IDLE;
    end
    else if (i_ce)
      st_reg <= st_next;
  end

  always_comb
  begin
    o_rdata            = st_reg.rdata;
    o_trig_accept      = st_reg.trig_accept;
    o_transfer_active  = st_reg.xfer_active;
    o_readout_chan     = st_reg.ro_chan;
    o_write_ptr        = st_reg.wr_ptr;
    o_ped_addr         = st_reg.ped_addr;
    o_baseline_thr     = st_reg.baseline_thr;
    o_buf_count_select = st_reg.buf_sel;
  end
endmodule

/* File: tb/ebsc_checker.sv */
/* assertions on the ports of the buffer control block.
   assumes it is bound onto ebsc_event_buffer_ctrl. */
`timescale 1ns/1ps
module ebsc_checker (
  input wire logic        i_core_clk,
  input wire logic        i_arst_n,
  input wire logic        i_ce,
  input wire logic [4:0]  i_addr,
  input wire logic [19:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic        i_bcast,
  input wire logic        i_parity,
  input wire logic        i_readout_done,
  input wire logic [19:0] o_rdata,
  input wire logic        o_transfer_active,
  input wire logic [2:0]  o_write_ptr,
  input wire logic [9:0]  o_ped_addr,
  input wire logic [13:0] o_baseline_thr,
  input wire logic        o_buf_count_select
);
  import ebsc_pkg::*;
  wire logic par_ok = i_parity == ^{i_addr, i_wdata, i_bcast};
  wire logic wr_ok  = i_ce && i_wr && par_ok;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  a_rdata_idle: assert property (
    !(i_ce && i_rd) |=> o_rdata == 20'h0)
    else $error("read data outside answer");
  a_ped_write: assert property (
    wr_ok && i_addr == OFS_PED_ADDR |=> o_ped_addr == $past(i_wdata[9:0]))
    else $error("pedestal address not written");
  a_thr_write: assert property (
    wr_ok && !i_bcast && i_addr == OFS_BASELINE_THR
      |=> o_baseline_thr == $past(i_wdata[13:0]))
    else $error("thresholds not written");
  a_thr_bcast: assert property (
    wr_ok && i_bcast && i_addr == OFS_BASELINE_THR |=> $stable(o_baseline_thr))
    else $error("broadcast threshold write taken");
  a_parity_drop: assert property (
    i_ce && i_wr && !par_ok && i_addr == OFS_PED_ADDR |=> $stable(o_ped_addr))
    else $error("bad parity write taken");
  a_cfg_write: assert property (
    wr_ok && i_addr == OFS_DATAPATH_CFG
      |=> o_buf_count_select == $past(i_wdata[CFG_BUF_SEL_BIT]))
    else $error("buffer count select not written");
  a_xfer_end: assert property (
    i_ce && o_transfer_active && i_readout_done |=> !o_transfer_active)
    else $error("transfer not ended");
  a_four_even: assert property (
    !o_buf_count_select |-> !o_write_ptr[0])
    else $error("odd pointer in four-buffer mode");
  cover property (wr_ok && i_addr == CMD_SOFT_TRIGGER);
  cover property (o_transfer_active && i_readout_done);
  cover property (wr_ok && i_bcast && i_addr == OFS_BASELINE_THR);
endmodule
bind ebsc_event_buffer_ctrl ebsc_checker chk_u (.i_core_clk, .i_arst_n,
  .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd, .i_bcast, .i_parity,
  .i_readout_done, .o_rdata, .o_transfer_active, .o_write_ptr,
  .o_ped_addr, .o_baseline_thr, .o_buf_count_select);

/* File: tb/ebsc_frontend_model.sv */
/* front-end stand-in: opens the processing window after each accepted
   trigger and ends a transfer some cycles later.
   assumes the core clock and reset of the block. */
`timescale 1ns/1ps
module ebsc_frontend_model #(
  parameter int WIN = 8,
  parameter int RO  = 5
) (
  input  wire logic i_core_clk,
  input  wire logic i_arst_n,
  input  wire logic i_trig_accept,
  input  wire logic i_transfer_active,
  output logic      o_proc_window,
  output logic      o_readout_done
);
  int win_cnt;
  int ro_cnt;
  assign o_proc_window = win_cnt != 0;
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      win_cnt        <= 0;
      ro_cnt         <= 0;
      o_readout_done <= 1'b0;
    end
    else
    begin
      win_cnt <= i_trig_accept ? WIN : (win_cnt > 0 ? win_cnt - 1 : 0);
      // transfer held back while acquisition runs
      o_readout_done <= i_transfer_active && !o_proc_window
                        && ro_cnt == RO;
      ro_cnt <= (i_transfer_active && ro_cnt < RO) ? ro_cnt + 1 : 0;
    end
  end
endmodule

/* File: tb/ebsc_event_buffer_ctrl_tb.sv */
/* bench for the buffer control block: bus tasks act as the readout
   controller; assumes the front-end model and the bound checker. */
`timescale 1ns/1ps
module ebsc_event_buffer_ctrl_tb;
  import ebsc_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, we = 1'b0, re = 1'b0;
  logic        bc = 1'b0, par = 1'b0, trig = 1'b0, win, dn, acc, xfer;
  logic [3:0]  ups = 4'h0, ch;
  logic [4:0]  ad = 5'h0;
  logic [15:0] nz = 16'ha5;
  logic [19:0] wd = 20'h0, rdat, rv;
  int          failures = 0, num_checks = 0, cyc = 0;
  always #2 clk = ~clk;
  ebsc_event_buffer_ctrl dut_u (.i_core_clk(clk), .i_arst_n(rst_n),
    .i_ce(1'b1), .i_addr(ad), .i_wdata(wd), .i_wr(we), .i_rd(re),
    .i_bcast(bc), .i_parity(par), .i_trig_pin(trig),
    .i_proc_window(win), .i_chan_nonzero(nz), .i_readout_done(dn),
    .i_buf_fsm_single_upset(ups[0]), .i_buf_fsm_double_upset(ups[1]),
    .i_if_single_upset(ups[2]), .i_if_double_upset(ups[3]),
    .o_rdata(rdat), .o_trig_accept(acc), .o_transfer_active(xfer),
    .o_readout_chan(ch), .o_write_ptr(), .o_ped_addr(),
    .o_baseline_thr(), .o_buf_count_select());
  ebsc_frontend_model fe_u (.i_core_clk(clk), .i_arst_n(rst_n),
    .i_trig_accept(acc), .i_transfer_active(xfer),
    .o_proc_window(win), .o_readout_done(dn));
  task automatic wrt(input logic [4:0] a, input logic [19:0] d = 20'h0,
                     input logic b = 1'b0, input logic bp = 1'b0);
    @(posedge clk);
    ad  <= a;
    wd  <= d;
    bc  <= b;
    par <= ^{a, d, b} ^ bp;
    we  <= 1'b1;
    @(posedge clk);
    we  <= 1'b0;
  endtask
  task automatic chk(input logic [19:0] g, input logic [19:0] e);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [4:0] a, input logic [19:0] e,
                     input logic [19:0] m = 20'hfffff);
    @(posedge clk);
    ad  <= a;
    bc  <= 1'b0;
    par <= ^{a, wd, 1'b0};
    re  <= 1'b1;
    @(posedge clk);
    re  <= 1'b0;
    #1 rv = rdat;
    chk(rv & m, e);
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      failures++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rdc(OFS_ERR_STATE, 20'h900);
    rdc(OFS_TRIG_COUNT, 20'h0);
    $display("test reset done");
    wrt(OFS_PED_ADDR, 20'h3ff, 1'b1);
    wrt(OFS_BASELINE_THR, 20'h2abc);
    wrt(OFS_BASELINE_THR, 20'h1555, 1'b1);
    wrt(OFS_PED_ADDR, 20'h11, 1'b0, 1'b1);
    rdc(OFS_BASELINE_THR, 20'h2abc);
    rdc(OFS_PED_ADDR, 20'h3ff);
    rdc(5'h1f, 20'h0);
    rdc(OFS_ERR_STATE, 20'h3900);
    wrt(CMD_CLEAR_ERRORS);
    rdc(OFS_ERR_STATE, 20'h900);
    $display("test registers done");
    repeat (4)
    begin
      wrt(CMD_SOFT_TRIGGER);
      repeat (20) @(posedge clk);
      wrt(CMD_WPTR_ADVANCE);
    end
    rdc(OFS_ERR_STATE, 20'h400);
    rdc(OFS_CHAN_MAP, 20'ha5);
    wrt(CMD_SOFT_TRIGGER);
    wrt(CMD_WPTR_ADVANCE);
    rdc(OFS_ERR_STATE, 20'h400);
    rdc(OFS_TRIG_COUNT, 20'h5);
    wrt(CMD_RPTR_ADVANCE);
    rdc(OFS_ERR_STATE, 20'h42);
    $display("test fill done");
    wrt(CMD_CHAN_READOUT, 20'h5);
    #1 chk({16'h0, ch}, 20'h5);
    chk({19'h0, xfer}, 20'h1);
    for (int k = 0; k < 100 && xfer; k++) @(posedge clk);
    #1 chk({19'h0, xfer}, 20'h0);
    wrt(CMD_SOFT_TRIGGER);
    wrt(CMD_SOFT_TRIGGER);
    rdc(OFS_ERR_STATE, 20'h4000, 20'h4000);
    wrt(CMD_CLEAR_COUNT);
    rdc(OFS_TRIG_COUNT, 20'h0);
    repeat (3) wrt(CMD_RPTR_ADVANCE);
    rdc(OFS_ERR_STATE, 20'h4900);
    wrt(CMD_CHAN_READOUT, 20'h3);
    #1 chk({19'h0, xfer}, 20'h0);
    rdc(OFS_ERR_STATE, 20'h84900);
    $display("test readout done");
    wrt(CMD_CLEAR_ERRORS);
    wrt(OFS_DATAPATH_CFG, 20'h10);
    rdc(OFS_ERR_STATE, 20'ha00);
    @(posedge clk);
    ups <= 4'hf;
    @(posedge clk);
    ups <= 4'h0;
    rdc(OFS_ERR_STATE, 20'h78000, 20'h78000);
    @(posedge clk);
    trig <= 1'b1;
    repeat (6) @(posedge clk);
    trig <= 1'b0;
    rdc(OFS_TRIG_COUNT, 20'h1);
    repeat (20) @(posedge clk);
    wrt(CMD_WPTR_ADVANCE);
    wrt(CMD_CHAN_READOUT, 20'h2);
    trig <= 1'b1;
    repeat (5) @(posedge clk);
    trig <= 1'b0;
    #1 chk({19'h0, xfer}, 20'h0);
    for (int k = 0; k < 100 && !xfer; k++) @(posedge clk);
    #1 chk({19'h0, xfer}, 20'h1);
    for (int k = 0; k < 100 && xfer; k++) @(posedge clk);
    #1 chk({19'h0, xfer}, 20'h0);
    $display("test errors done");
    end_of_test();
  end
endmodule
